// ==== mact_map.svh ====
// Notes on behaviour
// - each instruction totals reads, prefetches and writes, reported as r/p/w counts
// - table counts assume two-clock bus cycles, four-clock for word multi-register moves; slower cycles lengthen execution
// - byte or word operand is one bus cycle, long operand is two
// - long operand adds one two-clock bus cycle to total, tail unchanged; lookup adds two such cycles
// - alternate-space move runs save, then address step, then operation step
// - word multi-register alternate_space_move tolerate four-clock bus cycles at no extra cost
// - control-register move reaches only user stack, vector base, source and destination codes
// - word multi-register load: 8+4n clocks, n+1 reads, 2 prefetches, no writes
// - word multi-register store: 8+4n clocks, no reads, 2 prefetches, n writes
// - long multi-register load: 12+4n clocks, 2n+2 reads, 2 prefetches
// - long multi-register store: 10+4n clocks, 2 prefetches, 2n writes, tail nine
// - maximum entries may finish early but never exceed the listed bound
// - signed and unsigned multiply and lookup take identical time; signed divide totals 62, unsigned 46
// - bounds compare, multiply, divide, lookup: save, address, operation summed in order
// - long multiply and divide skip save when source is a data register
// - every accepted instruction adds an immediate fetch-address term (imm_clocks) to the total
// - slow bus clocks leave the head alone and extend the tail, not the reported total
`ifndef MACT_MAP_SVH
`define MACT_MAP_SVH
`define MACT_MULTI_REGISTER_MOVE_W_BASE   8'h08
`define MACT_MULTI_REGISTER_MOVE_L_LD     8'h0C
`define MACT_MULTI_REGISTER_MOVE_L_ST     8'h0A
`define MACT_PER_REG        8'h04
`define MACT_MULTI_REGISTER_MOVE_HEAD     8'h01
`define MACT_SAVE_HEAD      8'h01
`define MACT_SAVE_TAIL      8'h01
`define MACT_SAVE_TOTAL     8'h03
`define MACT_LONG_EXTRA     8'h02
`define MACT_CONTROL_REGISTER_MOVE_RD_HEAD  8'h0A
`define MACT_CONTROL_REGISTER_MOVE_RD_TOT   8'h0E
`define MACT_CONTROL_REGISTER_MOVE_WR_HEAD  8'h0C
`define MACT_CONTROL_REGISTER_MOVE_WR_TOT   8'h10
`define MACT_MOVS_LD_HEAD   8'h07
`define MACT_MOVS_LD_TOT    8'h0B
`define MACT_MOVS_ST_HEAD   8'h09
`define MACT_MOVS_ST_TAIL   8'h02
`define MACT_MOVS_ST_TOT    8'h0C
`define MACT_OP_HEAD        8'h02
`define MACT_BOUNDS_COMPARE_TOT       8'h12
`define MACT_MULL_TOT       8'h34
`define MACT_DIVUL_TOT      8'h2E
`define MACT_DIVSL_TOT      8'h3E
`define MACT_TBL_HEAD       8'h06
`define MACT_TBL_TOT        8'h23
`define MACT_BUS_STD        8'h02
`define MACT_BUS_MULTI_REGISTER_MOVE_W    8'h04
`define MACT_CR_USP         4'h0
`define MACT_CR_VBR         4'h1
`define MACT_CR_SFC         4'h2
`define MACT_CR_DFC         4'h3
`endif

// ==== mact_pkg.sv ====
package mact_pkg;
  typedef enum logic [3:0] {
    MACT_OP_MULTI_REGISTER_MOVE_W_LD, MACT_OP_MULTI_REGISTER_MOVE_W_ST, MACT_OP_MULTI_REGISTER_MOVE_L_LD, MACT_OP_MULTI_REGISTER_MOVE_L_ST,
    MACT_OP_CONTROL_REGISTER_MOVE_RD, MACT_OP_CONTROL_REGISTER_MOVE_WR, MACT_OP_MOVS_LD, MACT_OP_MOVS_ST,
    MACT_OP_BOUNDS_COMPARE, MACT_OP_MULL, MACT_OP_DIVUL, MACT_OP_DIVSL, MACT_OP_TBL
  } mact_op_t;
  typedef struct packed {
    mact_op_t    op;
    logic        is_long;
    logic        src_dreg;
    logic        signed_op;
    logic [4:0]  reg_count;
    logic [3:0]  ctl_reg;
    logic [7:0]  ea_clocks;
    logic [7:0]  imm_clocks;
  } mact_cmd_t;
  typedef struct packed {
    logic [7:0]  total;
    logic [7:0]  reads;
    logic [7:0]  prefetches;
    logic [7:0]  writes;
    logic        illegal;
  } mact_rep_t;
  typedef enum logic [2:0] {MACT_IDLE, MACT_SAVE, MACT_EA, MACT_HEAD, MACT_BUS, MACT_TAIL, MACT_DONE} mact_st_t;
  typedef struct packed {
    mact_st_t    st;
    mact_cmd_t   cmd;
    logic [7:0]  cnt;
    logic [7:0]  clocks;
    logic [7:0]  head;
    logic [7:0]  tail;
    logic [7:0]  bus_left;
    logic [7:0]  bus_slack;
    logic [7:0]  bus_len;
    logic        bus_req;
    logic        done;
    logic        busy;
    mact_rep_t   rep;
  } mact_state_t;
endpackage

// ==== mact_seq.sv ====
`timescale 1ns/100ps
`include "mact_map.svh"
module mact_seq (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // command from decoder
  input  wire logic              start,
  input  mact_pkg::mact_cmd_t    cmd,
  // bus interface
  input  wire logic              bus_ack,
  output logic                   bus_req,
  // results
  output logic                   busy,
  output logic                   done,
  output mact_pkg::mact_rep_t    report,
  output logic [7:0]             clocks
);
  mact_pkg::mact_state_t s_reg, s_next;

  // ==========================================
  // timing lookup
  function automatic logic [7:0] f_bus_cnt(input mact_pkg::mact_cmd_t c);
    logic [7:0] n;
    n = {3'b000, c.reg_count};
    f_bus_cnt = 8'h00;
    case (c.op)
      mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_W_LD: f_bus_cnt = n + 8'h01;
      mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_W_ST: f_bus_cnt = n;
      mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_L_LD: f_bus_cnt = 8'(n << 1) + 8'h02;
      mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_L_ST: f_bus_cnt = 8'(n << 1);
      mact_pkg::MACT_OP_MOVS_LD, mact_pkg::MACT_OP_MOVS_ST, mact_pkg::MACT_OP_BOUNDS_COMPARE:
        f_bus_cnt = c.is_long ? 8'h02 : 8'h01;
      mact_pkg::MACT_OP_TBL: f_bus_cnt = c.is_long ? 8'h04 : 8'h02;
      default: f_bus_cnt = 8'h00;
    endcase
  endfunction

  function automatic logic f_has_save(input mact_pkg::mact_cmd_t c);
    case (c.op)
      mact_pkg::MACT_OP_MOVS_LD, mact_pkg::MACT_OP_MOVS_ST: f_has_save = 1'b1;
      mact_pkg::MACT_OP_BOUNDS_COMPARE, mact_pkg::MACT_OP_TBL: f_has_save = 1'b1;
      mact_pkg::MACT_OP_MULL, mact_pkg::MACT_OP_DIVUL, mact_pkg::MACT_OP_DIVSL:
        f_has_save = !c.src_dreg;
      default: f_has_save = 1'b0;
    endcase
  endfunction

  // operation total (bound), head, prefetch count
  function automatic logic [23:0] f_operation_time(input mact_pkg::mact_cmd_t c);
    logic [7:0] n4;
    logic [7:0] lx;
    n4 = 8'({3'b000, c.reg_count} << 2);
    lx = c.is_long ? `MACT_LONG_EXTRA : 8'h00;
    f_operation_time = 24'h00_0000;
    case (c.op)
      mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_W_LD, mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_W_ST:
        f_operation_time = {`MACT_MULTI_REGISTER_MOVE_W_BASE + n4, `MACT_MULTI_REGISTER_MOVE_HEAD, 8'h02};
      mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_L_LD: f_operation_time = {`MACT_MULTI_REGISTER_MOVE_L_LD + n4, `MACT_MULTI_REGISTER_MOVE_HEAD, 8'h02};
      mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_L_ST: f_operation_time = {`MACT_MULTI_REGISTER_MOVE_L_ST + n4, `MACT_MULTI_REGISTER_MOVE_HEAD, 8'h02};
      mact_pkg::MACT_OP_CONTROL_REGISTER_MOVE_RD: f_operation_time = {`MACT_CONTROL_REGISTER_MOVE_RD_TOT, `MACT_CONTROL_REGISTER_MOVE_RD_HEAD, 8'h02};
      mact_pkg::MACT_OP_CONTROL_REGISTER_MOVE_WR: f_operation_time = {`MACT_CONTROL_REGISTER_MOVE_WR_TOT, `MACT_CONTROL_REGISTER_MOVE_WR_HEAD, 8'h01};
      mact_pkg::MACT_OP_MOVS_LD: f_operation_time = {`MACT_MOVS_LD_TOT + lx, `MACT_MOVS_LD_HEAD, 8'h01};
      mact_pkg::MACT_OP_MOVS_ST: f_operation_time = {`MACT_MOVS_ST_TOT + lx, `MACT_MOVS_ST_HEAD, 8'h01};
      mact_pkg::MACT_OP_BOUNDS_COMPARE: f_operation_time = {`MACT_BOUNDS_COMPARE_TOT + lx, `MACT_OP_HEAD, 8'h01};
      mact_pkg::MACT_OP_MULL: f_operation_time = {`MACT_MULL_TOT, `MACT_OP_HEAD, 8'h01};
      mact_pkg::MACT_OP_DIVUL: f_operation_time = {`MACT_DIVUL_TOT, `MACT_OP_HEAD, 8'h01};
      mact_pkg::MACT_OP_DIVSL: f_operation_time = {`MACT_DIVSL_TOT, `MACT_OP_HEAD, 8'h01};
      mact_pkg::MACT_OP_TBL: f_operation_time = {`MACT_TBL_TOT + lx + lx, `MACT_TBL_HEAD, 8'h01};
      default: f_operation_time = 24'h00_0000;
    endcase
  endfunction

  // ==========================================
  // next state
  always_comb begin
    logic [23:0] o;
    logic [7:0]  nbus;
    logic [7:0]  blen;
    logic [7:0]  body;
    logic        is_wr;
    logic        wmovem;
    o      = f_operation_time(s_reg.cmd);
    nbus   = f_bus_cnt(s_reg.cmd);
    s_next = s_reg;
    s_next.done    = 1'b0;
    s_next.bus_req = 1'b0;
    s_next.clocks  = s_reg.busy ? s_reg.clocks + 8'h01 : s_reg.clocks;
    is_wr  = (s_reg.cmd.op == mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_W_ST) || (s_reg.cmd.op == mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_L_ST)
             || (s_reg.cmd.op == mact_pkg::MACT_OP_MOVS_ST);
    wmovem = (s_reg.cmd.op == mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_W_LD) || (s_reg.cmd.op == mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_W_ST);
    blen   = wmovem ? `MACT_BUS_MULTI_REGISTER_MOVE_W : `MACT_BUS_STD;
    body   = 8'(nbus * blen);
    case (s_reg.st)
      mact_pkg::MACT_IDLE: begin
        if (start) begin
          s_next.cmd    = cmd;
          s_next.busy   = 1'b1;
          s_next.clocks = 8'h00;
          s_next.rep    = '0;
          if ((cmd.op == mact_pkg::MACT_OP_CONTROL_REGISTER_MOVE_RD || cmd.op == mact_pkg::MACT_OP_CONTROL_REGISTER_MOVE_WR)
              && cmd.ctl_reg > `MACT_CR_DFC) begin
            s_next.rep.illegal = 1'b1;
            s_next.st          = mact_pkg::MACT_DONE;
          end else begin
            s_next.cnt = cmd.imm_clocks;
            s_next.st  = mact_pkg::MACT_SAVE;
          end
        end
      end
      mact_pkg::MACT_SAVE: begin
        if (s_reg.cnt != 8'h00) begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end else begin
          s_next.rep.total      = s_reg.cmd.imm_clocks + (f_has_save(s_reg.cmd) ? `MACT_SAVE_TOTAL : 8'h00);
          s_next.rep.prefetches = f_has_save(s_reg.cmd) ? 8'h01 : 8'h00;
          s_next.cnt = f_has_save(s_reg.cmd) ? `MACT_SAVE_TOTAL : 8'h00;
          s_next.st  = mact_pkg::MACT_EA;
        end
      end
      mact_pkg::MACT_EA: begin
        if (s_reg.cnt != 8'h00) begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end else if (s_reg.cmd.ea_clocks != 8'h00) begin
          s_next.cnt           = s_reg.cmd.ea_clocks - 8'h01;
          s_next.rep.total     = s_reg.rep.total + s_reg.cmd.ea_clocks;
          s_next.cmd.ea_clocks = 8'h00;
        end else begin
          s_next.head      = o[15:8];
          s_next.tail      = o[23:16] - o[15:8] - body;
          s_next.bus_left  = nbus;
          s_next.bus_slack = 8'h00;
          s_next.bus_len   = 8'h00;
          s_next.rep.total = s_reg.rep.total + o[23:16];
          s_next.rep.prefetches = s_reg.rep.prefetches + o[7:0];
          s_next.rep.reads      = is_wr ? 8'h00 : nbus;
          s_next.rep.writes     = is_wr ? nbus : 8'h00;
          s_next.st  = mact_pkg::MACT_HEAD;
        end
      end
      mact_pkg::MACT_HEAD: begin
        if (s_reg.head > 8'h01) begin
          s_next.head = s_reg.head - 8'h01;
        end else if (s_reg.bus_left != 8'h00) begin
          s_next.bus_req = 1'b1;
          s_next.st      = mact_pkg::MACT_BUS;
        end else begin
          s_next.st = mact_pkg::MACT_TAIL;
        end
      end
      mact_pkg::MACT_BUS: begin
        // wait for ack; slow cycles stretch
        s_next.bus_len = s_reg.bus_len + 8'h01;
        if (bus_ack) begin
          if (s_reg.bus_len + 8'h01 > blen)
            s_next.tail = s_reg.tail + s_reg.bus_len + 8'h01 - blen;
          s_next.bus_len  = 8'h00;
          s_next.bus_left = s_reg.bus_left - 8'h01;
          if (s_reg.bus_left == 8'h01) begin
            s_next.st = mact_pkg::MACT_TAIL;
          end else begin
            s_next.bus_req = 1'b1;
          end
        end else begin
          s_next.bus_req = 1'b1;
        end
      end
      mact_pkg::MACT_TAIL: begin
        if (s_reg.tail > 8'h01) begin
          s_next.tail = s_reg.tail - 8'h01;
        end else begin
          s_next.st = mact_pkg::MACT_DONE;
        end
      end
      default: begin
        s_next.done = 1'b1;
        s_next.busy = 1'b0;
        s_next.st   = mact_pkg::MACT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus_req = s_reg.bus_req;
  assign busy    = s_reg.busy;
  assign done    = s_reg.done;
  assign report  = s_reg.rep;
  assign clocks  = s_reg.clocks;
endmodule // mact_seq

// ==== mact_monitor.sv ====
`timescale 1ns/100ps
module mact_monitor (
  // clock and reset
  input wire logic           clk,
  input wire logic           rst_n,
  // decoder and bus
  input wire logic           start,
  input mact_pkg::mact_cmd_t cmd,
  input wire logic           bus_ack,
  input wire logic           bus_req,
  // results
  input wire logic           busy,
  input wire logic           done,
  input mact_pkg::mact_rep_t report,
  input wire logic [7:0]     clocks
);
  mact_pkg::mact_cmd_t cq;
  logic [7:0]          n;
  // command kept from the taking edge, report is judged against it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      cq <= '0;
    else if (start && !busy)
      cq <= cmd;
  end
  assign n = {3'h0, cq.reg_count};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; start && !busy; endsequence
  sequence s_fin; done && !busy; endsequence
  take_busy_a: assert property (s_take |=> busy) else $error("busy missing");
  done_pulse_a: assert property (done |=> !done) else $error("done too long");
  done_idle_a: assert property (done |-> !busy) else $error("busy at done");
  req_hold_a: assert property (bus_req && !bus_ack |=> bus_req) else $error("request dropped");
  req_idle_a: assert property (!busy |-> !bus_req) else $error("request while idle");
  rep_stand_a: assert property (!busy && !start |=> $stable(report)) else $error("report moved");
  bad_ctl_a: assert property (s_take ##0 (cmd.op == mact_pkg::MACT_OP_CONTROL_REGISTER_MOVE_RD && cmd.ctl_reg > 4'h3)
    |-> ##[1:4] (done && report.illegal)) else $error("illegal not flagged");
  word_load_a: assert property (s_fin ##0 (cq.op == mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_W_LD) |->
    report.total == 8'h08 + 8'h04 * n + cq.ea_clocks + cq.imm_clocks && report.reads == n + 8'h01)
    else $error("word load");
  long_store_a: assert property (s_fin ##0 (cq.op == mact_pkg::MACT_OP_MULTI_REGISTER_MOVE_L_ST) |->
    report.writes == n + n && report.reads == 8'h00) else $error("long store");
  save_skip_a: assert property (s_fin ##0 (cq.op == mact_pkg::MACT_OP_MULL && cq.src_dreg) |->
    report.total == 8'h34 + cq.ea_clocks + cq.imm_clocks) else $error("save not skipped");
  // elapsed count only runs while an instruction is in flight
  clk_stand_a: assert property (!busy && !start |=> $stable(clocks)) else $error("clocks moved");
endmodule // mact_monitor
bind mact_seq mact_monitor mon_u (.clk(clk), .rst_n(rst_n), .start(start), .cmd(cmd), .bus_ack(bus_ack),
  .bus_req(bus_req), .busy(busy), .done(done), .report(report), .clocks(clocks));

// ==== mact_mem_model.sv ====
`timescale 1ns/100ps
module mact_mem_model (
  // clock and reset
  input wire logic  clk,
  input wire logic  rst_n,
  // bus side
  input wire logic  bus_req,
  input wire logic  slow,
  output logic      bus_ack
);
  logic [1:0] wait_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 2'h0;
      bus_ack <= 1'b0;
    end else if (bus_req && !bus_ack && wait_reg == (slow ? 2'h2 : 2'h0)) begin
      wait_reg <= 2'h0;
      bus_ack <= 1'b1;
    end else begin
      wait_reg <= (bus_req && !bus_ack) ? wait_reg + 2'h1 : 2'h0;
      bus_ack <= 1'b0;
    end
  end
endmodule // mact_mem_model

// ==== mact_seq_test.sv ====
`timescale 1ns/100ps
`define CHK_EQ(nm, e, g) tests_run++; if ((g) !== (e)) begin miscompares++; $display("unexpected %s exp %h got %h", nm, e, g); end
module mact_seq_test;
  typedef struct packed {logic full; mact_pkg::mact_rep_t rep;} mact_exp_t;
  logic                clk, rst_n, start, slow, bus_ack, bus_req, busy, done;
  mact_pkg::mact_cmd_t cmd, c;
  mact_pkg::mact_rep_t report;
  logic [7:0]          clocks, n, ea, im, tt;
  logic [7:0]          base [7] = '{8'd11, 8'd12, 8'd18, 8'd52, 8'd46, 8'd62, 8'd35};
  mact_exp_t           expq[$];
  mact_exp_t           e;
  int                  miscompares, tests_run, seed, i, k, acks;
  mact_seq dut_u (.clk(clk), .rst_n(rst_n), .start(start), .cmd(cmd), .bus_ack(bus_ack), .bus_req(bus_req),
    .busy(busy), .done(done), .report(report), .clocks(clocks));
  mact_mem_model mem_u (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .slow(slow), .bus_ack(bus_ack));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic run(input mact_pkg::mact_cmd_t cc, input mact_exp_t ee);
    int t;
    expq.push_back(ee);
    @(posedge clk);
    cmd <= cc;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 3000) begin
      @(posedge clk);
      t++;
    end
    if (t >= 3000) begin
      miscompares++;
      print_verdict();
    end
  endtask
  // result watcher takes the oldest note per done
  always @(posedge clk) begin
    if (bus_ack === 1'b1)
      acks++;
    if (done === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      `CHK_EQ("illegal", e.rep.illegal, report.illegal)
      if (!e.rep.illegal) begin
        `CHK_EQ("total", e.rep.total, report.total)
      end
      if (e.full) begin
        `CHK_EQ("reads", e.rep.reads, report.reads)
        `CHK_EQ("prefetches", e.rep.prefetches, report.prefetches)
        `CHK_EQ("writes", e.rep.writes, report.writes)
        `CHK_EQ("bus_cycles", e.rep.reads + e.rep.writes, 8'(acks))
      end
      acks = 0;
    end
  end
  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    slow = 1'b0;
    cmd = '0;
    seed = 32'ha4ea7576;
    acks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 16; i++) begin
      k = i % 4;
      c = '0;
      n = 8'(($random(seed) & 15) + 1);
      ea = 8'($random(seed) & 7);
      slow <= (k < 2) ? 1'($random(seed)) : 1'b0;
      c.op = mact_pkg::mact_op_t'(k);
      c.is_long = (k > 1);
      c.reg_count = n[4:0];
      c.ea_clocks = ea;
      case (k)
        0: run(c, {1'b1, 8'd8 + 8'd4 * n + ea, n + 8'd1, 8'd2, 8'd0, 1'b0});
        1: run(c, {1'b1, 8'd8 + 8'd4 * n + ea, 8'd0, 8'd2, n, 1'b0});
        2: run(c, {1'b1, 8'd12 + 8'd4 * n + ea, n + n + 8'd2, 8'd2, 8'd0, 1'b0});
        default: run(c, {1'b1, 8'd10 + 8'd4 * n + ea, 8'd0, 8'd2, n + n, 1'b0});
      endcase
    end
    slow <= 1'b0;
    // control register codes, 4 and 5 refused
    for (i = 0; i < 12; i++) begin
      c = '0;
      c.op = (i < 6) ? mact_pkg::MACT_OP_CONTROL_REGISTER_MOVE_RD : mact_pkg::MACT_OP_CONTROL_REGISTER_MOVE_WR;
      c.ctl_reg = 4'(i % 6);
      run(c, {i % 6 < 4, (i < 6) ? 8'd14 : 8'd16, 8'd0, (i < 6) ? 8'd2 : 8'd1, 8'd0, i % 6 > 3});
    end
    for (i = 0; i < 28; i++) begin
      k = 6 + i % 7;
      c = '0;
      ea = 8'($random(seed) & 7);
      im = 8'($random(seed) & 3);
      c.op = mact_pkg::mact_op_t'(k);
      c.signed_op = 1'((i / 7) % 2);
      c.src_dreg = (k > 8 && k < 12) ? 1'($random(seed)) : 1'b0;
      c.is_long = (k < 8) ? 1'($random(seed)) : 1'b0;
      c.ea_clocks = ea;
      c.imm_clocks = im;
      tt = base[k - 6] + (c.src_dreg ? 8'd0 : 8'd3) + ea + im + (c.is_long ? 8'd2 : 8'd0);
      run(c, {1'b0, tt, 8'd0, 8'd0, 8'd0, 1'b0});
    end
    // reset in mid-run clears the outputs
    @(posedge clk);
    cmd <= c;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    `CHK_EQ("busy", 1'b0, busy)
    `CHK_EQ("bus_req", 1'b0, bus_req)
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK_EQ("pending", 0, expq.size())
    print_verdict();
  end
endmodule // mact_seq_test
